/* common/plc_map.svh */
// register map, field positions and reset values of the logic cell block
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH

// register byte offsets
`define PLC_OFF_CTRL     8'h00
`define PLC_OFF_DRIVE    8'h04
`define PLC_OFF_SRC_LO   8'h08
`define PLC_OFF_SRC_HI   8'h0C
`define PLC_OFF_STATUS   8'h10

// control register fields
`define PLC_CTRL_MODE_LO 0
`define PLC_CTRL_MODE_HI 1
`define PLC_CTRL_OE      2
`define PLC_CTRL_FREE    3
`define PLC_CTRL_SET_T   4
`define PLC_CTRL_RST_T   5
`define PLC_CTRL_SW_SET  6
`define PLC_CTRL_SW_RST  7
`define PLC_CTRL_W       8

// cell gate inputs: a 19..14, f 13..8, b 7..6, c 5..4, d 3..2, e 1..0
`define PLC_NUM_IN       20
`define PLC_SRC_W        3
`define PLC_SRC_PER_REG  10
`define PLC_SRC_REG_W    30

// status register fields
`define PLC_ST_AZ        0
`define PLC_ST_FZ        1
`define PLC_ST_OZ        2
`define PLC_ST_NZ        3
`define PLC_ST_QZ        4
`define PLC_ST_PAD       5
`define PLC_ST_DED_T     6
`define PLC_ST_DED_C     7
`define PLC_ST_TREE      8
`define PLC_ST_W         9

// reset values
`define PLC_RST_CTRL     8'h00
`define PLC_RST_DRIVE    20'h00000
`define PLC_RST_SRC      30'h00000000
`define PLC_RST_WORD     32'h00000000

`endif

/* common/plc_pkg.sv */
// types shared by the logic cell block
package plc_pkg;

  // where one gate input of the cell is wired to
  typedef enum logic [2:0] {
    SRC_ZERO,
    SRC_ONE,
    SRC_DRIVE,
    SRC_Q,
    SRC_PAD,
    SRC_DED_T,
    SRC_DED_C,
    SRC_TREE
  } plc_src_type;

  // pad driver polarity
  typedef enum logic [1:0] {
    PAD_HIGH,
    PAD_LOW,
    PAD_ODRAIN,
    PAD_SPARE
  } plc_pad_mode_type;

  // gate inputs of one cell
  typedef struct packed {
    logic [5:0] a;
    logic [5:0] f;
    logic [1:0] b;
    logic [1:0] c;
    logic [1:0] d;
    logic [1:0] e;
  } plc_cell_in_type;

  // combinational outputs of one cell
  typedef struct packed {
    logic az;
    logic fz;
    logic oz;
    logic nz;
  } plc_cell_out_type;

endpackage

/* design/plc_cell_gates.sv */
// gate and multiplexer part of one logic cell
`timescale 1ns/1ns
module plc_cell_gates
  import plc_pkg::*;
(
  input  wire plc_cell_in_type  cell_in,
  output plc_cell_out_type      cell_out
);

  logic b_and;
  logic c_and;
  logic d_and;
  logic e_and;
  logic mux_lo;
  logic mux_hi;

  // two wide and gates, four narrow ones
  assign cell_out.az = &cell_in.a;
  assign cell_out.fz = &cell_in.f;
  assign b_and       = &cell_in.b;
  assign c_and       = &cell_in.c;
  assign d_and       = &cell_in.d;
  assign e_and       = &cell_in.e;

  // mux tree: first level steered by a, final level by f
  assign mux_lo      = cell_out.az ? c_and : b_and;
  assign mux_hi      = cell_out.az ? e_and : d_and;
  assign cell_out.oz = mux_lo;
  assign cell_out.nz = cell_out.fz ? mux_hi : mux_lo;

endmodule

/* design/plc_cell_top.sv */
// one configurable logic cell with its pad cells and apb configuration port
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "plc_map.svh"

module plc_cell_top
  import plc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              io_pad_in,
  output logic                   io_pad_out,
  output logic                   io_pad_oe,
  input  wire logic              ded_pad_in,
  input  wire logic              clk_pad_in,
  output logic                   cell_az,
  output logic                   cell_fz,
  output logic                   cell_oz,
  output logic                   cell_nz,
  output logic                   cell_qz,
  output logic                   ded_true,
  output logic                   ded_comp
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [`PLC_CTRL_W-1:0]    ctrl_q;
  logic [`PLC_NUM_IN-1:0]    drive_q;
  logic [`PLC_SRC_REG_W-1:0] src_lo_q;
  logic [`PLC_SRC_REG_W-1:0] src_hi_q;
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      io_s1_q;
  logic                      io_s2_q;
  logic                      ded_s1_q;
  logic                      ded_s2_q;
  logic                      clk_s1_q;
  logic                      tree_q;
  logic                      tree_prev_q;
  logic                      az_q;
  logic                      fz_q;
  logic                      oz_q;
  logic                      nz_q;
  logic                      qz_q;
  logic                      pad_out_q;
  logic                      pad_oe_q;
  logic                      ded_t_q;
  logic                      ded_c_q;
  logic [`PLC_NUM_IN-1:0]    gate_in;
  logic [2*`PLC_SRC_REG_W-1:0] src_all;
  plc_cell_in_type           cell_in;
  plc_cell_out_type          cell_out;
  plc_pad_mode_type          pad_mode;
  logic                      setup_ph;
  logic                      wr_fire;
  logic                      addr_ok;
  logic [31:0]               rd_word;
  logic [`PLC_ST_W-1:0]      status;
  logic                      set_a;
  logic                      rst_a;
  logic                      cap_en;
  logic                      or_v;

  // refuse an address bus too narrow for the map
  if (ADDR_W < 5) begin : g_chk
    $error("plc_cell_top: ADDR_W must be at least 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // two flops per pin before any logic looks at it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      io_s1_q  <= 1'b0;
      io_s2_q  <= 1'b0;
      ded_s1_q <= 1'b0;
      ded_s2_q <= 1'b0;
      clk_s1_q <= 1'b0;
      tree_q   <= 1'b0;
    end else if (ce) begin
      io_s1_q  <= io_pad_in;
      io_s2_q  <= io_s1_q;
      ded_s1_q <= ded_pad_in;
      ded_s2_q <= ded_s1_q;
      clk_s1_q <= clk_pad_in;
      tree_q   <= clk_s1_q;
    end
  end

  // previous tree level for rising edge detection
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tree_prev_q <= 1'b0;
    end else if (ce) begin
      tree_prev_q <= tree_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  assign setup_ph = psel && !pready_q;
  assign wr_fire  = psel && penable && pready_q && pwrite;
  assign addr_ok  = (paddr[ADDR_W-1:0] == ADDR_W'(`PLC_OFF_CTRL))
                 || (paddr[ADDR_W-1:0] == ADDR_W'(`PLC_OFF_DRIVE))
                 || (paddr[ADDR_W-1:0] == ADDR_W'(`PLC_OFF_SRC_LO))
                 || (paddr[ADDR_W-1:0] == ADDR_W'(`PLC_OFF_SRC_HI))
                 || (paddr[ADDR_W-1:0] == ADDR_W'(`PLC_OFF_STATUS));

  // live status of the cell and pads
  assign status = {tree_q, ded_c_q, ded_t_q, io_s2_q, qz_q, nz_q, oz_q, fz_q, az_q};

  // read mux, unmapped reads as zero
  always_comb begin
    rd_word = `PLC_RST_WORD;
    unique case (paddr[ADDR_W-1:0])
      ADDR_W'(`PLC_OFF_CTRL):   rd_word[`PLC_CTRL_W-1:0]    = ctrl_q;
      ADDR_W'(`PLC_OFF_DRIVE):  rd_word[`PLC_NUM_IN-1:0]    = drive_q;
      ADDR_W'(`PLC_OFF_SRC_LO): rd_word[`PLC_SRC_REG_W-1:0] = src_lo_q;
      ADDR_W'(`PLC_OFF_SRC_HI): rd_word[`PLC_SRC_REG_W-1:0] = src_hi_q;
      ADDR_W'(`PLC_OFF_STATUS): rd_word[`PLC_ST_W-1:0]      = status;
      default:                  rd_word = `PLC_RST_WORD;
    endcase
  end

  // answer in the first access cycle, data caught in setup
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      prdata_q  <= `PLC_RST_WORD;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        prdata_q  <= pwrite ? `PLC_RST_WORD : rd_word;
        pslverr_q <= !addr_ok;
      end
    end
  end

  // configuration registers; these are the programmed links of the cell
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q   <= `PLC_RST_CTRL;
      drive_q  <= `PLC_RST_DRIVE;
      src_lo_q <= `PLC_RST_SRC;
      src_hi_q <= `PLC_RST_SRC;
    end else if (ce && wr_fire) begin
      unique case (paddr[ADDR_W-1:0])
        ADDR_W'(`PLC_OFF_CTRL):   ctrl_q   <= pwdata[`PLC_CTRL_W-1:0];
        ADDR_W'(`PLC_OFF_DRIVE):  drive_q  <= pwdata[`PLC_NUM_IN-1:0];
        ADDR_W'(`PLC_OFF_SRC_LO): src_lo_q <= pwdata[`PLC_SRC_REG_W-1:0];
        ADDR_W'(`PLC_OFF_SRC_HI): src_hi_q <= pwdata[`PLC_SRC_REG_W-1:0];
        default: ;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // gate input wiring

  assign src_all = {src_hi_q, src_lo_q};

  // each gate input picks a constant or a net; nothing else sets the function
  for (genvar i = 0; i < `PLC_NUM_IN; i++) begin : g_src
    plc_src_type sel;
    assign sel = plc_src_type'(src_all[i*`PLC_SRC_W +: `PLC_SRC_W]);
    always_comb begin
      unique case (sel)
        SRC_ZERO:  gate_in[i] = 1'b0;
        SRC_ONE:   gate_in[i] = 1'b1;
        SRC_DRIVE: gate_in[i] = drive_q[i];
        SRC_Q:     gate_in[i] = qz_q;
        SRC_PAD:   gate_in[i] = io_s2_q;
        SRC_DED_T: gate_in[i] = ded_s2_q;
        SRC_DED_C: gate_in[i] = !ded_s2_q;
        SRC_TREE:  gate_in[i] = tree_q;
      endcase
    end
  end

  assign cell_in = plc_cell_in_type'(gate_in);

  plc_cell_gates u_gates (
    .cell_in  (cell_in),
    .cell_out (cell_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // cell outputs and storage flop

  // all four gate outputs are kept visible alongside the register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      az_q <= 1'b0;
      fz_q <= 1'b0;
      oz_q <= 1'b0;
      nz_q <= 1'b0;
    end else if (ce) begin
      az_q <= cell_out.az;
      fz_q <= cell_out.fz;
      oz_q <= cell_out.oz;
      nz_q <= cell_out.nz;
    end
  end

  // set and reset from software or the clock tree
  assign set_a  = ctrl_q[`PLC_CTRL_SW_SET] || (ctrl_q[`PLC_CTRL_SET_T] && tree_q);
  assign rst_a  = ctrl_q[`PLC_CTRL_SW_RST] || (ctrl_q[`PLC_CTRL_RST_T] && tree_q);
  assign cap_en = ctrl_q[`PLC_CTRL_FREE] || (tree_q && !tree_prev_q);

  // storage flop; set and reset bypass the cell clock
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      qz_q <= 1'b0;
    end else if (ce) begin
      if (rst_a) begin
        qz_q <= 1'b0;
      end else if (set_a) begin
        qz_q <= 1'b1;
      end else if (cap_en) begin
        qz_q <= cell_out.nz;
      end
    end
  end

  assign cell_az = az_q;
  assign cell_fz = fz_q;
  assign cell_oz = oz_q;
  assign cell_nz = nz_q;
  assign cell_qz = qz_q;

  ////////////////////////////////////////////////////////////////////////////
  // pad cells

  assign pad_mode = plc_pad_mode_type'(ctrl_q[`PLC_CTRL_MODE_HI:`PLC_CTRL_MODE_LO]);
  assign or_v     = cell_out.nz || cell_out.fz;

  // pad driver with selectable polarity
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
    end else if (ce) begin
      unique case (pad_mode)
        PAD_LOW: begin
          pad_out_q <= !or_v;
          pad_oe_q  <= ctrl_q[`PLC_CTRL_OE];
        end
        PAD_ODRAIN: begin
          pad_out_q <= 1'b0;
          pad_oe_q  <= ctrl_q[`PLC_CTRL_OE] && or_v;
        end
        default: begin
          pad_out_q <= or_v;
          pad_oe_q  <= ctrl_q[`PLC_CTRL_OE];
        end
      endcase
    end
  end

  // dedicated input, true and complement
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ded_t_q <= 1'b0;
      ded_c_q <= 1'b1;
    end else if (ce) begin
      ded_t_q <= ded_s2_q;
      ded_c_q <= !ded_s2_q;
    end
  end

  assign io_pad_out = pad_out_q;
  assign io_pad_oe  = pad_oe_q;
  assign ded_true   = ded_t_q;
  assign ded_comp   = ded_c_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_reset_wins_set: assert property (ce && rst_a |=> !qz_q)
    else $error("flop not cleared by reset");

  a_set_forces_q: assert property (ce && set_a && !rst_a |=> qz_q)
    else $error("flop not forced by set");

  a_capture_mux_result: assert property (
    ce && !rst_a && !set_a && cap_en |=> qz_q == $past(cell_out.nz))
    else $error("flop did not capture mux result");

  a_hold_no_edge: assert property (
    ce && !rst_a && !set_a && !cap_en |=> $stable(qz_q))
    else $error("flop changed without a tree edge");

  a_odrain_pad: assert property (ce && pad_mode == PAD_ODRAIN |=>
    !io_pad_out && io_pad_oe == $past(ctrl_q[`PLC_CTRL_OE] && or_v))
    else $error("open drain pad drove wrong level");

  a_pad_or_low: assert property (ce && pad_mode == PAD_LOW |=>
    io_pad_out == !($past(cell_out.nz) || $past(cell_out.fz)))
    else $error("active low pad does not follow or");

  a_ded_pair: assert property (ded_true != ded_comp)
    else $error("dedicated input pair not complementary");

  a_wide_and_out: assert property (ce |=> cell_az == $past(&cell_in.a)
    && cell_fz == $past(&cell_in.f))
    else $error("wide and output wrong");

  a_tree_edge_cap: assert property (ce && !ctrl_q[`PLC_CTRL_FREE] && !set_a && !rst_a
    && tree_q && !tree_prev_q |=> qz_q == $past(cell_out.nz))
    else $error("tree rising edge did not clock flop");

  a_apb_one_wait: assert property (ce && psel && !penable && !pready |=> pready
    ##1 (!$past(ce) || !pready))
    else $error("apb answer timing wrong");

endmodule

/* tb/programmable_logic_cell_tb.sv */
// self-checking bench for the logic cell block with its pad cells
`timescale 1ns/1ns
`include "plc_map.svh"
module programmable_logic_cell_tb;

  // one table row: drive levels, control word, expected {az,fz,oz,nz,pad_out,pad_oe}
  typedef struct packed {
    logic [19:0] drv;
    logic [7:0]  ctl;
    logic [5:0]  exp;
  } plc_row_type;

  localparam plc_row_type ROWS [8] = '{
    '{20'h00000, 8'h06, 6'h00}, '{20'hFFFFF, 8'h05, 6'h3D},
    '{20'hFC000, 8'h05, 6'h23}, '{20'hFC030, 8'h06, 6'h2D},
    '{20'h000C0, 8'h00, 6'h0E}, '{20'h03F0C, 8'h07, 6'h17},
    '{20'hFFF30, 8'h02, 6'h38}, '{20'h7FFFF, 8'h04, 6'h1F}};

  logic        sys_clk, rstn, ce, psel, penable, pwrite;
  logic        io_pad_in, ded_pad_in, clk_pad_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic        pready, pslverr, err, io_pad_out, io_pad_oe;
  logic        cell_az, cell_fz, cell_oz, cell_nz, cell_qz, ded_true, ded_comp;
  int          failures, check_count;

  plc_cell_top i_dut (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .ce         (ce),
    .paddr      (paddr),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .io_pad_in  (io_pad_in),
    .io_pad_out (io_pad_out),
    .io_pad_oe  (io_pad_oe),
    .ded_pad_in (ded_pad_in),
    .clk_pad_in (clk_pad_in),
    .cell_az    (cell_az),
    .cell_fz    (cell_fz),
    .cell_oz    (cell_oz),
    .cell_nz    (cell_nz),
    .cell_qz    (cell_qz),
    .ded_true   (ded_true),
    .ded_comp   (ded_comp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one apb transfer, waits for pready under a bounded count
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd  = prdata;
    err = pslverr;
    if (n >= 16) begin
      failures++;
      $display("Error at %0t: no bus answer", $time);
    end
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  // all ten gate input selects of one word set to one code
  function automatic logic [31:0] fill(input logic [2:0] c);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 10; i++) v[i*3 +: 3] = c;
    return v;
  endfunction

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected run
  initial begin
    #1000000;
    failures++;
    $display("Error at %0t: timeout", $time);
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'h0; ce = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 8'h00; pwdata = 32'h0; io_pad_in = 1'h0; ded_pad_in = 1'h0;
    clk_pad_in = 1'h0; failures = 0; check_count = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    // reset state of outputs and registers
    chk({cell_az, cell_fz, cell_oz, cell_nz, cell_qz}, 5'h00, "reset cell");
    chk({io_pad_oe, ded_true, ded_comp, pready}, 4'h2, "reset misc");
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      chk({err, rd}, 33'h0, "reset reg");
    end
    // unmapped places and the read-only status
    apb(1'h0, 8'h14, 32'h0);
    chk({err, rd}, 33'h100000000, "unmapped read");
    apb(1'h1, 8'h20, 32'hFFFFFFFF);
    chk(err, 1'h1, "unmapped write");
    apb(1'h1, `PLC_OFF_STATUS, 32'hFFFFFFFF);
    chk(err, 1'h0, "status write");
    apb(1'h1, `PLC_OFF_DRIVE, 32'hFFFFFFFF);
    apb(1'h0, `PLC_OFF_DRIVE, 32'h0);
    chk(rd, 32'h000FFFFF, "drive width");
    // every gate input follows its drive bit
    apb(1'h1, `PLC_OFF_SRC_LO, fill(3'h2));
    apb(1'h1, `PLC_OFF_SRC_HI, fill(3'h2));
    apb(1'h0, `PLC_OFF_SRC_LO, 32'h0);
    chk(rd, fill(3'h2), "src readback");
    // table of gate patterns and pad modes
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, `PLC_OFF_DRIVE, {12'h000, ROWS[i].drv});
      apb(1'h1, `PLC_OFF_CTRL, {24'h000000, ROWS[i].ctl});
      wt(3);
      chk({cell_az, cell_fz, cell_oz, cell_nz}, ROWS[i].exp[5:2], "cell outs");
      chk({io_pad_out, io_pad_oe}, ROWS[i].exp[1:0], "pad out");
      apb(1'h0, `PLC_OFF_STATUS, 32'h0);
      chk(rd[3:0], {ROWS[i].exp[2], ROWS[i].exp[3], ROWS[i].exp[4], ROWS[i].exp[5]},
          "status");
    end
    // flop: hold without tree edge, capture on rising tree edge
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000080);
    wt(2);
    chk(cell_qz, 1'h0, "sw reset");
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000000);
    apb(1'h1, `PLC_OFF_DRIVE, 32'h000FFFFF);
    wt(6);
    chk(cell_qz, 1'h0, "hold");
    clk_pad_in <= 1'h1;
    wt(6);
    chk(cell_qz, 1'h1, "tree capture");
    clk_pad_in <= 1'h0;
    // free-running capture follows the final mux
    apb(1'h1, `PLC_OFF_DRIVE, 32'h0);
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000008);
    wt(3);
    chk(cell_qz, 1'h0, "free run low");
    apb(1'h1, `PLC_OFF_DRIVE, 32'h000FFFFF);
    wt(3);
    chk(cell_qz, 1'h1, "free run high");
    // set and reset, reset winning, and from the tree
    apb(1'h1, `PLC_OFF_CTRL, 32'h000000C0);
    wt(2);
    chk(cell_qz, 1'h0, "both");
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000040);
    wt(2);
    chk(cell_qz, 1'h1, "sw set");
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000020);
    wt(4);
    chk(cell_qz, 1'h1, "tree reset idle");
    clk_pad_in <= 1'h1;
    wt(6);
    chk(cell_qz, 1'h0, "tree reset");
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000010);
    wt(2);
    chk(cell_qz, 1'h1, "tree set");
    clk_pad_in <= 1'h0;
    // dedicated input and pad input levels
    ded_pad_in <= 1'h1;
    io_pad_in  <= 1'h1;
    wt(5);
    chk({ded_true, ded_comp}, 2'h2, "dedicated");
    apb(1'h0, `PLC_OFF_STATUS, 32'h0);
    chk(rd[7:5], 3'h3, "pad status");
    // tree as a plain mux input: b bit from tree, a held low, rest tied high
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000000);
    w = fill(3'h1);
    w[20:18] = 3'h7;
    apb(1'h1, `PLC_OFF_SRC_LO, w);
    w = fill(3'h1);
    w[29:27] = 3'h0;
    apb(1'h1, `PLC_OFF_SRC_HI, w);
    clk_pad_in <= 1'h1;
    wt(5);
    chk({cell_az, cell_fz, cell_oz, cell_nz}, 4'h7, "tree mux high");
    clk_pad_in <= 1'h0;
    wt(5);
    chk({cell_az, cell_fz, cell_oz, cell_nz}, 4'h5, "tree mux low");
    // counter stage: a from q, b from dedicated true and pad, c from complement
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000080);
    apb(1'h1, `PLC_OFF_SRC_LO, 32'h0094E000);
    apb(1'h1, `PLC_OFF_SRC_HI, 32'h0924B000);
    apb(1'h1, `PLC_OFF_CTRL, 32'h00000008);
    wt(1);
    chk(cell_qz, 1'h1, "toggle first");
    wt(1);
    chk(cell_qz, 1'h0, "toggle second");
    // clock enable low freezes the toggling flop
    ce <= 1'h0;
    wt(2);
    chk(cell_qz, 1'h1, "ce freeze");
    ce <= 1'h1;
    wt(2);
    chk(cell_qz, 1'h0, "ce resume");
    // carry-in low holds the count
    ded_pad_in <= 1'h0;
    wt(4);
    chk(cell_qz, 1'h1, "carry hold");
    wt(1);
    chk(cell_qz, 1'h1, "carry hold again");
    // second reset in mid-run
    rstn <= 1'h0;
    wt(2);
    rstn <= 1'h1;
    wt(1);
    chk({cell_qz, ded_true, ded_comp}, 3'h1, "mid reset cell");
    apb(1'h0, `PLC_OFF_SRC_LO, 32'h0);
    chk({err, rd}, 33'h0, "mid reset src");
    summarize();
  end

endmodule
